// ==== verilog/sam_pkg.sv ====
// Constants, pin group and state codes for the split-address mux bus port.
// Assumes the configuration word is supplied by the command logic of the device.
package sam_pkg;

   localparam int SAM_AD_W = 16;
   localparam int SAM_UPPER_W = 10;
   localparam int SAM_LATENCY = 4;
   localparam int SAM_WL_BITS = 4;
   localparam int SAM_WL_WAIT = 2;
   localparam int SAM_CFG_W = 16;

   // Configuration word bit positions
   localparam int SAM_CFG_ASYNC_BIT = 15;
   localparam int SAM_CFG_SPLIT_BIT = 4;

   // Sampling clock and flash bus clock rates in kHz
   localparam int SAM_SYS_CLK_KHZ = 10000;
   localparam int SAM_FCLK_MIN_KHZ = 9600;
   localparam int SAM_EDGE_SAMPLES = 4;
   localparam int SAM_FCLK_MAX_KHZ = SAM_SYS_CLK_KHZ / SAM_EDGE_SAMPLES;

   typedef struct packed {
      logic fclk;
      logic ce_n;
      logic adv_n;
      logic oe_n;
      logic we_n;
   } sam_ctl_s;

   // Idle pin levels: clock low, strobes high
   localparam sam_ctl_s SAM_CTL_IDLE = 5'h0F;

   typedef enum logic [3:0] {
      RD_IDLE = 4'h1,
      RD_SENSE = 4'h2,
      RD_DATA = 4'h4,
      RD_WLWAIT = 4'h8
   } sam_rd_e;

endpackage

// ==== verilog/sam_sync.sv ====
// Three-stage pin synchroniser; a bit changes once stages two and three agree.
// Assumes inputs are asynchronous to i_clk.
`timescale 1ns/100ps
module sam_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input wire logic i_clk,
   input wire logic i_rst_b,
   input wire logic [W-1:0] i_d,
   output logic [W-1:0] o_q
);

   logic [W-1:0] s1_reg, s2_reg, s3_reg, q_reg;
   logic [W-1:0] q_next;

   always_comb begin
      q_next = q_reg;
      for (int i = 0; i < W; i++) begin
         if (s2_reg[i] == s3_reg[i]) begin
            q_next[i] = s3_reg[i];
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         s1_reg <= RST_VAL;
         s2_reg <= RST_VAL;
         s3_reg <= RST_VAL;
         q_reg <= RST_VAL;
      end else begin
         s1_reg <= i_d;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         q_reg <= q_next;
      end
   end

   assign o_q = q_reg;

endmodule

// ==== verilog/sam_port.sv ====
// Device-side address capture and read/write sequencing for the split-address mux bus.
// Assumes pins arrive unsynchronised and the array answers sense requests on I_CLK.
//
// Summary of operation
// [RULE1] Host pulses address valid once or twice per asynchronous bus cycle.
// [RULE2] Two pulses: output enable low captures upper, then high captures lower.
// [RULE3] Asynchronous reads start sensing only once the lower address is latched.
// [RULE4] Without an upper phase, the last latched upper bits are reused.
// [RULE5] Asynchronous access is timed from the address valid rising edge.
// [RULE6] Host may restart a pending read only once before one completes.
// [RULE7] Synchronous mode: upper with enable low, lower with enable high, upper optional.
// [RULE8] Synchronous phases latch on bus clock rise; sensing starts at lower.
// [RULE9] Address valid may stay low; phases latch on two consecutive clocks.
// [RULE10] Host drives output enable like address valid during synchronous capture.
// [RULE11] Host lowers output enable only after its address hold time.
// [RULE12] Host meets output enable setup and hold around address valid rise.
// [RULE13] Writes happen on write enable rise, independent of the bus clock.
// [RULE14] Burst operation works down to the low bus clock rate; sampling covers bus clocks only up to 2500 kHz, under the 9600 kHz minimum.
// [RULE15] No-wrap bursts insert wait states at each word line end.
// [RULE16] Boot runs from the lowest region before split mode is enabled.
// [RULE17] Split mode off at reset; entering it clears upper bits to zero.
// [RULE18] Wait drives exactly with data; async always valid, sync after latency.
// [RULE19] Single phase with enable high is lower address; data follows enable low.
`timescale 1ns/100ps
module sam_port
   import sam_pkg::*;
#(
   parameter int UPPER_W = SAM_UPPER_W,
   parameter int LATENCY = SAM_LATENCY,
   parameter int WL_BITS = SAM_WL_BITS,
   parameter int WL_WAIT = SAM_WL_WAIT
) (
   input wire logic I_CLK,
   input wire logic I_RST_B,
   input wire logic I_FCLK,
   input wire logic I_CE_N,
   input wire logic I_ADV_N,
   input wire logic I_OE_N,
   input wire logic I_WE_N,
   input wire logic [SAM_AD_W-1:0] I_AD,
   input wire logic [SAM_CFG_W-1:0] I_READ_CONFIG,
   input wire logic [SAM_AD_W-1:0] I_ARR_DATA,
   input wire logic I_ARR_VALID,
   output logic [SAM_AD_W-1:0] O_AD,
   output logic O_AD_OE,
   output logic O_WAIT,
   output logic O_WAIT_OE,
   output logic [SAM_AD_W+UPPER_W-1:0] O_ARR_ADDR,
   output logic O_SENSE_START,
   output logic O_WR_STB,
   output logic [SAM_AD_W+UPPER_W-1:0] O_WR_ADDR,
   output logic [SAM_AD_W-1:0] O_WR_DATA
);

   localparam int AW = SAM_AD_W + UPPER_W;
   localparam int LW = $clog2(LATENCY + 1);
   localparam int CW = $clog2(WL_WAIT + 2);

   if (UPPER_W < 1 || UPPER_W > SAM_AD_W) begin : g_chk_upper
      $error("UPPER_W must lie between 1 and the bus width");
   end
   if (LATENCY < 1 || WL_BITS < 1 || WL_BITS >= SAM_AD_W || WL_WAIT < 0) begin : g_chk_burst
      $error("Burst latency, word line size or wait count out of range");
   end
   if (SAM_FCLK_MIN_KHZ > SAM_FCLK_MAX_KHZ) begin : g_chk_rate
      $error("Sampling clock too slow for the lowest burst clock");
   end

   sam_ctl_s ctl_raw, ctl, ctl_prev_reg, ctl_prev_next;
   logic [SAM_AD_W-1:0] ad_in;

   assign ctl_raw = {I_FCLK, I_CE_N, I_ADV_N, I_OE_N, I_WE_N};

   sam_sync #(
      .W($bits(sam_ctl_s)),
      .RST_VAL(SAM_CTL_IDLE)
   ) u_ctl_sync (
      .i_clk(I_CLK),
      .i_rst_b(I_RST_B),
      .i_d(ctl_raw),
      .o_q(ctl)
   );

   sam_sync #(
      .W(SAM_AD_W),
      .RST_VAL('0)
   ) u_bus_sync (
      .i_clk(I_CLK),
      .i_rst_b(I_RST_B),
      .i_d(I_AD),
      .o_q(ad_in)
   );

   // Configuration and pin events
   logic async_mode, split_en;
   logic adv_rise, fclk_rise, we_rise;
   logic cap_ev, cap_upper, cap_lower;

   assign async_mode = I_READ_CONFIG[SAM_CFG_ASYNC_BIT];
   assign split_en = I_READ_CONFIG[SAM_CFG_SPLIT_BIT];
   assign adv_rise = ~ctl_prev_reg.adv_n & ctl.adv_n;
   assign fclk_rise = ~ctl_prev_reg.fclk & ctl.fclk;
   assign we_rise = ~ctl_prev_reg.we_n & ctl.we_n;

   // State
   logic split_prev_reg, split_prev_next;
   logic addr_done_reg, addr_done_next;
   logic [UPPER_W-1:0] upper_reg, upper_next;
   logic [SAM_AD_W-1:0] lower_reg, lower_next;
   sam_rd_e rd_reg, rd_next;
   logic [LW-1:0] lat_reg, lat_next;
   logic [CW-1:0] wl_reg, wl_next;
   logic [SAM_AD_W-1:0] data_reg, data_next;
   logic [AW-1:0] arr_addr_reg, arr_addr_next;
   logic sense_reg, sense_next;
   logic [SAM_AD_W-1:0] ad_out_reg, ad_out_next;
   logic ad_oe_reg, ad_oe_next;
   logic wait_reg, wait_next;
   logic wr_stb_reg, wr_stb_next;
   logic [AW-1:0] wr_addr_reg, wr_addr_next;
   logic [SAM_AD_W-1:0] wr_data_reg, wr_data_next;
   logic step, wl_end;

   // Capture: ADV# rise when async, bus clock rise with ADV# low when sync
   assign cap_ev = ~ctl.ce_n & (async_mode ? adv_rise : (fclk_rise & ~ctl.adv_n & ~addr_done_reg)); // see [RULE8]
   assign cap_upper = cap_ev & split_en & ~ctl.oe_n; // see [RULE2] see [RULE7]
   assign cap_lower = cap_ev & ~cap_upper; // see [RULE19]

   // Burst hands a word over on a bus clock rise once latency is spent
   assign step = ~async_mode & fclk_rise & ~ctl.oe_n & (lat_reg == '0);
   assign wl_end = &arr_addr_reg[WL_BITS-1:0];

   always_comb begin
      ctl_prev_next = ctl;
      split_prev_next = split_en;
      addr_done_next = addr_done_reg;
      upper_next = upper_reg;
      lower_next = lower_reg;
      rd_next = rd_reg;
      lat_next = lat_reg;
      wl_next = wl_reg;
      data_next = data_reg;
      arr_addr_next = arr_addr_reg;
      sense_next = 1'b0;
      wr_stb_next = 1'b0;
      wr_addr_next = wr_addr_reg;
      wr_data_next = wr_data_reg;

      // Upper bits held zero outside split mode and on entry
      if (~split_en || ~split_prev_reg) begin
         upper_next = '0; // see [RULE17]
      end else if (cap_upper) begin
         upper_next = ad_in[UPPER_W-1:0]; // see [RULE2] see [RULE4]
      end

      // Synchronous phase ends with lower capture; ADV# held low allows two clocks
      if (ctl.adv_n || ctl.ce_n) begin
         addr_done_next = 1'b0;
      end else if (cap_lower && !async_mode) begin
         addr_done_next = 1'b1; // see [RULE9]
      end

      if (cap_lower) begin
         // Sensing starts at lower latch; a new lower address restarts a pending read
         lower_next = ad_in;
         arr_addr_next = {upper_reg, ad_in}; // see [RULE4] see [RULE7]
         sense_next = 1'b1; // see [RULE3] see [RULE5] see [RULE6]
         rd_next = RD_SENSE;
         lat_next = LW'(LATENCY);
      end else if (ctl.ce_n) begin
         rd_next = RD_IDLE;
      end else begin
         if (!async_mode && fclk_rise && lat_reg != '0 && rd_reg != RD_IDLE) begin
            lat_next = lat_reg - 1'b1; // see [RULE14]
         end
         case (rd_reg)
            RD_IDLE: begin
               rd_next = RD_IDLE;
            end
            RD_SENSE: begin
               if (I_ARR_VALID) begin
                  data_next = I_ARR_DATA;
                  rd_next = RD_DATA;
               end
            end
            RD_DATA: begin
               if (step && wl_end) begin
                  rd_next = RD_WLWAIT; // see [RULE15]
                  wl_next = CW'(WL_WAIT);
               end else if (step) begin
                  arr_addr_next = arr_addr_reg + 1'b1;
                  sense_next = 1'b1;
                  rd_next = RD_SENSE;
               end
            end
            RD_WLWAIT: begin
               if (fclk_rise && wl_reg == '0) begin
                  arr_addr_next = arr_addr_reg + 1'b1;
                  sense_next = 1'b1;
                  rd_next = RD_SENSE;
               end else if (fclk_rise) begin
                  wl_next = wl_reg - 1'b1; // see [RULE15]
               end
            end
            default: begin
               rd_next = RD_IDLE;
            end
         endcase
      end

      // Write taken on WE# rise, whatever the bus clock does
      if (we_rise && !ctl.ce_n) begin
         wr_stb_next = 1'b1; // see [RULE13]
         wr_addr_next = {upper_reg, lower_reg};
         wr_data_next = ad_in;
      end
   end

   // Data and wait drive together, only after the address phase is over
   always_comb begin
      ad_oe_next = ~ctl.ce_n & ~ctl.oe_n & ctl.we_n & ctl.adv_n & (rd_reg != RD_IDLE); // see [RULE19] see [RULE18]
      ad_out_next = data_reg;
      wait_next = ~async_mode & ((lat_reg != '0) | (rd_reg != RD_DATA)); // see [RULE18] see [RULE15]
   end

   always_ff @(posedge I_CLK or negedge I_RST_B) begin
      if (!I_RST_B) begin
         ctl_prev_reg <= SAM_CTL_IDLE;
         split_prev_reg <= 1'b0;
         addr_done_reg <= 1'b0;
         upper_reg <= '0;
         lower_reg <= '0;
         rd_reg <= RD_IDLE;
         lat_reg <= '0;
         wl_reg <= '0;
         data_reg <= '0;
         arr_addr_reg <= '0;
         sense_reg <= 1'b0;
         ad_out_reg <= '0;
         ad_oe_reg <= 1'b0;
         wait_reg <= 1'b0;
         wr_stb_reg <= 1'b0;
         wr_addr_reg <= '0;
         wr_data_reg <= '0;
      end else begin
         ctl_prev_reg <= ctl_prev_next;
         split_prev_reg <= split_prev_next;
         addr_done_reg <= addr_done_next;
         upper_reg <= upper_next;
         lower_reg <= lower_next;
         rd_reg <= rd_next;
         lat_reg <= lat_next;
         wl_reg <= wl_next;
         data_reg <= data_next;
         arr_addr_reg <= arr_addr_next;
         sense_reg <= sense_next;
         ad_out_reg <= ad_out_next;
         ad_oe_reg <= ad_oe_next;
         wait_reg <= wait_next;
         wr_stb_reg <= wr_stb_next;
         wr_addr_reg <= wr_addr_next;
         wr_data_reg <= wr_data_next;
      end
   end

   assign O_AD = ad_out_reg;
   assign O_AD_OE = ad_oe_reg;
   assign O_WAIT = wait_reg;
   assign O_WAIT_OE = ad_oe_reg;
   assign O_ARR_ADDR = arr_addr_reg;
   assign O_SENSE_START = sense_reg;
   assign O_WR_STB = wr_stb_reg;
   assign O_WR_ADDR = wr_addr_reg;
   assign O_WR_DATA = wr_data_reg;

endmodule

// ==== bench/sam_port_properties.sv ====
// Checker on the split-address mux bus port pins.
// Assumes host pins hold each level for three clocks or more.
`timescale 1ns/100ps
module sam_port_chk
   import sam_pkg::*;
(
   input wire logic I_CLK,
   input wire logic I_RST_B,
   input wire logic I_FCLK,
   input wire logic I_CE_N,
   input wire logic I_ADV_N,
   input wire logic I_OE_N,
   input wire logic I_WE_N,
   input wire logic [SAM_CFG_W-1:0] I_READ_CONFIG,
   input wire logic O_AD_OE,
   input wire logic O_WAIT,
   input wire logic O_WAIT_OE,
   input wire logic O_SENSE_START,
   input wire logic O_WR_STB
);
   logic asy;
   logic spl;
   assign asy = I_READ_CONFIG[SAM_CFG_ASYNC_BIT];
   assign spl = I_READ_CONFIG[SAM_CFG_SPLIT_BIT];
   default clocking @(posedge I_CLK); endclocking
   default disable iff (!I_RST_B);
   sequence adv_lower_s;
      asy && (I_OE_N || !spl) && !I_CE_N && $rose(I_ADV_N);
   endsequence
   sequence adv_upper_s;
      asy && spl && !I_OE_N && !I_CE_N && $rose(I_ADV_N);
   endsequence
   sequence clk_lower_s;
      !asy && I_OE_N && !I_ADV_N && !I_CE_N && $rose(I_FCLK);
   endsequence
   sequence clk_upper_s;
      !asy && spl && !I_OE_N && !I_ADV_N && !I_CE_N && $rose(I_FCLK);
   endsequence
   lower_sense_a: assert property (adv_lower_s |-> ##[3:6] O_SENSE_START)
      else $error("no sense after lower address");
   upper_quiet_a: assert property (adv_upper_s |-> ##3 !O_SENSE_START [*4])
      else $error("sense after upper address");
   clk_sense_a: assert property (clk_lower_s |-> ##[3:7] O_SENSE_START)
      else $error("no sense after clocked lower address");
   clk_upper_a: assert property (clk_upper_s |-> ##3 !O_SENSE_START [*4])
      else $error("sense after clocked upper address");
   sense_pulse_a: assert property (O_SENSE_START |=> !O_SENSE_START)
      else $error("sense pulse too long");
   write_edge_a: assert property (!I_CE_N && $rose(I_WE_N) |-> ##[3:6] O_WR_STB)
      else $error("no write after write enable rise");
   write_pulse_a: assert property (O_WR_STB |=> !O_WR_STB)
      else $error("write pulse too long");
   wait_drive_a: assert property (O_WAIT_OE == O_AD_OE)
      else $error("wait drive differs from data drive");
   async_wait_a: assert property (asy [*4] |-> !O_WAIT)
      else $error("wait raised in async mode");
   drive_cause_a: assert property (O_AD_OE |-> !$past(I_OE_N, 4) || !$past(I_OE_N, 5) || !$past(I_OE_N, 6))
      else $error("data driven without output enable");
endmodule
bind sam_port sam_port_chk chk (.I_CLK, .I_RST_B, .I_FCLK, .I_CE_N, .I_ADV_N, .I_OE_N, .I_WE_N, .I_READ_CONFIG,
   .O_AD_OE, .O_WAIT, .O_WAIT_OE, .O_SENSE_START, .O_WR_STB);

// ==== bench/sam_host.sv ====
// Host controller model driving the multiplexed bus pins.
// Assumes the bench calls one task at a time.
`timescale 1ns/100ps
module sam_host
   import sam_pkg::*;
(
   input wire logic i_clk,
   output sam_ctl_s o_ctl,
   output logic [SAM_AD_W-1:0] o_ad
);
   initial begin
      o_ctl = SAM_CTL_IDLE;
      o_ad = 16'h0000;
   end
   task automatic wt(input int n);
      repeat (n) @(negedge i_clk);
   endtask
   task automatic tick();
      wt(3);
      o_ctl.fclk = 1'b1;
      wt(3);
      o_ctl.fclk = 1'b0;
   endtask
   // One strobed address phase, then address valid released and the bus lines inverted
   task automatic aphase(input logic oe, input logic [SAM_AD_W-1:0] a);
      o_ctl.ce_n = 1'b0;
      o_ctl.oe_n = oe;
      o_ad = a;
      o_ctl.adv_n = 1'b0;
      wt(4);
      o_ctl.adv_n = 1'b1;
      wt(4);
      o_ad = ~a;
      wt(1);
   endtask
   // One clocked address phase; hold keeps address valid low
   task automatic sphase(input logic oe, input logic [SAM_AD_W-1:0] a, input logic hold);
      o_ctl.ce_n = 1'b0;
      o_ctl.oe_n = oe;
      o_ctl.adv_n = 1'b0;
      o_ad = a;
      tick();
      o_ctl.adv_n = !hold;
      o_ad = ~a;
      wt(1);
   endtask
   task automatic rd(input int beats);
      o_ctl.oe_n = 1'b0;
      wt(16);
      repeat (beats) tick();
   endtask
   task automatic wr(input logic [SAM_AD_W-1:0] d);
      o_ctl.we_n = 1'b0;
      o_ad = d;
      wt(4);
      o_ctl.we_n = 1'b1;
      wt(4);
      o_ad = ~d;
   endtask
   task automatic done();
      wt(1);
      o_ctl = SAM_CTL_IDLE;
      wt(6);
   endtask
endmodule

// ==== bench/sam_port_test.sv ====
// Self-checking bench for the split-address mux bus port.
// Assumes the host model drives pins and a behavioural array answers senses.
`timescale 1ns/100ps
module sam_port_test;
   import sam_pkg::*;
   localparam int AW = SAM_AD_W + SAM_UPPER_W;
   logic clk;
   logic rst_b;
   logic [SAM_CFG_W-1:0] cfg;
   logic [SAM_AD_W-1:0] ad_in, ad_out, h_ad, arr_data, wr_data, l, d;
   logic arr_valid, ad_oe, wait_o, wait_oe, sense, wr_stb;
   logic [AW-1:0] arr_addr, wr_addr, e, last, wexp;
   logic [SAM_UPPER_W-1:0] u;
   logic [AW-1:0] expq[$];
   sam_ctl_s ctl;
   int num_errors = 0;
   int num_checks = 0;
   int wait_seen = 0;
   int dly = 0;
   int wrs = 0;
   assign ad_in = ad_oe ? ad_out : h_ad;
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   sam_host host (.i_clk(clk), .o_ctl(ctl), .o_ad(h_ad));
   sam_port dut (.I_CLK(clk), .I_RST_B(rst_b), .I_FCLK(ctl.fclk), .I_CE_N(ctl.ce_n), .I_ADV_N(ctl.adv_n),
      .I_OE_N(ctl.oe_n), .I_WE_N(ctl.we_n), .I_AD(ad_in), .I_READ_CONFIG(cfg), .I_ARR_DATA(arr_data),
      .I_ARR_VALID(arr_valid), .O_AD(ad_out), .O_AD_OE(ad_oe), .O_WAIT(wait_o), .O_WAIT_OE(wait_oe),
      .O_ARR_ADDR(arr_addr), .O_SENSE_START(sense), .O_WR_STB(wr_stb), .O_WR_ADDR(wr_addr), .O_WR_DATA(wr_data));
   function automatic logic [SAM_AD_W-1:0] word(input logic [AW-1:0] a);
      return a[15:0] ^ 16'(a[AW-1:16]) ^ 16'h5a3c;
   endfunction
   // Configuration word with random unused bits around the mode bits
   function automatic logic [SAM_CFG_W-1:0] cfg_word(input logic asy, input logic spl);
      logic [SAM_CFG_W-1:0] c;
      c = SAM_CFG_W'($urandom);
      c[SAM_CFG_ASYNC_BIT] = asy;
      c[SAM_CFG_SPLIT_BIT] = spl;
      return c;
   endfunction
   task automatic chk_aw(input logic [AW-1:0] got, input logic [AW-1:0] exp);
      num_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("Error at %0t: address %h, expected %h", $time, got, exp);
      end
   endtask
   task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("Error at %0t: value %h, expected %h", $time, got, exp);
      end
   endtask
   task automatic tally_and_finish();
      $display("checks %0d, mismatches %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // Array with a random stall; pending data is noise
   always @(negedge clk) begin
      if (sense === 1'b1) begin
         e = expq.size() > 0 ? expq.pop_front() : last + 1'b1;
         chk_aw(arr_addr, e);
         last = e;
         arr_valid = 1'b0;
         dly = 1 + $urandom % 6;
      end else if (dly > 0) begin
         arr_valid = dly == 1;
         arr_data = dly == 1 ? word(last) : 16'($urandom);
         dly--;
      end
      if (wr_stb === 1'b1) begin
         chk_aw(wr_addr, wexp);
         chk16(wr_data, d);
         wrs++;
      end
      if (wait_o === 1'b1 && wait_oe === 1'b1) wait_seen++;
   end
   initial begin
      repeat (5000) @(posedge clk);
      $display("Error at %0t: watchdog expired", $time);
      num_errors++;
      tally_and_finish();
   end
   initial begin
      void'($urandom(32'hacaf));
      cfg = cfg_word(1'b1, 1'b0);
      rst_b = 1'b0;
      arr_valid = 1'b0;
      arr_data = 16'h0000;
      last = '0;
      u = '0;
      repeat (8) @(negedge clk);
      rst_b = 1'b1;
      host.wt(6);
      for (int i = 0; i < 6; i++) begin
         cfg = cfg_word(1'b1, i != 0);
         host.wt(2);
         l = 16'($urandom);
         if (i == 2 || i == 4) begin
            u = SAM_UPPER_W'($urandom);
            host.aphase(1'b0, 16'(u));
         end
         if (i == 3) begin
            expq.push_back({u, ~l});
            host.aphase(1'b1, ~l);
         end
         expq.push_back({u, l});
         host.aphase(i != 0, l);
         host.rd(0);
         chk16(ad_out, word({u, l}));
         chk16(16'(ad_oe), 16'h0001);
         host.done();
         $display("async read %0d done", i);
      end
      cfg = cfg_word(1'b0, 1'b1);
      u = SAM_UPPER_W'($urandom);
      l = {12'($urandom), 4'hd};
      expq.push_back({u, l});
      host.sphase(1'b0, 16'(u), 1'b1);
      host.sphase(1'b1, l, 1'b0);
      wait_seen = 0;
      host.rd(12);
      chk16(16'(wait_seen > 0), 16'h0001);
      host.done();
      $display("sync burst done");
      for (int m = 0; m < 2; m++) begin
         cfg = cfg_word(m == 0, 1'b1);
         host.wt(4);
         if (m == 0) u = SAM_UPPER_W'($urandom);
         l = 16'($urandom);
         d = 16'($urandom);
         wexp = {u, l};
         expq.push_back(wexp);
         if (m == 0) begin
            host.aphase(1'b0, 16'(u));
            host.aphase(1'b1, l);
         end else begin
            host.sphase(1'b1, l, 1'b0);
         end
         host.wr(d);
         host.done();
         $display("write %0d done", m);
      end
      host.wt(20);
      chk16(16'(expq.size()), 16'h0000);
      chk16(16'(wrs), 16'h0002);
      tally_and_finish();
   end
endmodule
